//--- hw/shreg_top.sv
// universal shift register with pin or software control over an axi4-lite slave
//
// Overview of operation
// - clear low forces all four stages low, whatever else is applied.
// - clear high with clock low: inputs ignored, stages keep their levels.
// - with clear high, stages change only on a rising clock edge, never high or falling.
// - both mode selects high: rising edge loads parallel inputs into stages.
// - select pattern 01: shift right, serial right input into A, D dropped.
// - select pattern 10: shift left, serial left input into D, A dropped.
// - while shifting, parallel data inputs have no effect.
// - both mode selects low: stages hold regardless of clock and data.
`timescale 1ns/1ps
`default_nettype none

module shreg_top (
  input  wire logic                                ref_clk_in,
  input  wire logic                                srst_in,
  input  wire logic                                clear_n_in,
  input  wire logic                                mode_sel_hi_in,
  input  wire logic                                mode_sel_lo_in,
  input  wire logic                                ser_right_in,
  input  wire logic                                ser_left_in,
  input  wire logic [shreg_pkg::STAGES-1:0]        par_data_in,
  input  wire logic                                shift_clk_in,
  output logic      [shreg_pkg::STAGES-1:0]        stage_out,
  input  wire logic [shreg_pkg::ADDR_W-1:0]        s_axi_awaddr_in,
  input  wire logic                                s_axi_awvalid_in,
  output logic                                     s_axi_awready_out,
  input  wire logic [shreg_pkg::DATA_W-1:0]        s_axi_wdata_in,
  input  wire logic [shreg_pkg::STRB_W-1:0]        s_axi_wstrb_in,
  input  wire logic                                s_axi_wvalid_in,
  output logic                                     s_axi_wready_out,
  output logic      [1:0]                          s_axi_bresp_out,
  output logic                                     s_axi_bvalid_out,
  input  wire logic                                s_axi_bready_in,
  input  wire logic [shreg_pkg::ADDR_W-1:0]        s_axi_araddr_in,
  input  wire logic                                s_axi_arvalid_in,
  output logic                                     s_axi_arready_out,
  output logic      [shreg_pkg::DATA_W-1:0]        s_axi_rdata_out,
  output logic      [1:0]                          s_axi_rresp_out,
  output logic                                     s_axi_rvalid_out,
  input  wire logic                                s_axi_rready_in
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SEL_CTRL = 3'b001,
    SEL_STAT = 3'b010,
    SEL_NONE = 3'b100
  } sel_type;

  function automatic sel_type reg_sel(input logic [shreg_pkg::ADDR_W-1:0] a);
    sel_type s;
    if (a == shreg_pkg::CTRL_OFS) begin
      s = SEL_CTRL;
    end else if (a == shreg_pkg::STAT_OFS) begin
      s = SEL_STAT;
    end else begin
      s = SEL_NONE;
    end
    return s;
  endfunction

  // ----------------------------------------------------------------
  // write channel state
  // ----------------------------------------------------------------
  logic                          awready_r,  awready_nxt;
  logic                          wready_r,   wready_nxt;
  logic                          bvalid_r,   bvalid_nxt;
  logic [1:0]                    bresp_r,    bresp_nxt;
  logic [shreg_pkg::ADDR_W-1:0]  waddr_r,    waddr_nxt;
  logic [shreg_pkg::DATA_W-1:0]  wdata_r,    wdata_nxt;
  logic [shreg_pkg::STRB_W-1:0]  wstrb_r,    wstrb_nxt;
  logic [shreg_pkg::DATA_W-1:0]  ctrl_r,     ctrl_nxt;
  logic [shreg_pkg::DATA_W-1:0]  ctrl_wr;
  logic                          have_a,     have_d;

  // address and data are captured independently; the commit waits for both
  always_comb begin
    awready_nxt = awready_r;
    wready_nxt  = wready_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    waddr_nxt   = waddr_r;
    wdata_nxt   = wdata_r;
    wstrb_nxt   = wstrb_r;
    ctrl_nxt    = ctrl_r;
    ctrl_wr     = ctrl_r;
    if (s_axi_awvalid_in && awready_r) begin
      awready_nxt = 1'b0;
      waddr_nxt   = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && wready_r) begin
      wready_nxt = 1'b0;
      wdata_nxt  = s_axi_wdata_in;
      wstrb_nxt  = s_axi_wstrb_in;
    end
    have_a = ~awready_nxt;
    have_d = ~wready_nxt;
    if (bvalid_r) begin
      if (s_axi_bready_in) begin
        bvalid_nxt  = 1'b0;
        awready_nxt = 1'b1;
        wready_nxt  = 1'b1;
      end
    end else if (have_a && have_d) begin
      for (int b = 0; b < shreg_pkg::STRB_W; b++) begin
        if (wstrb_nxt[b]) begin
          ctrl_wr[b*8 +: 8] = wdata_nxt[b*8 +: 8];
        end
      end
      unique case (reg_sel(waddr_nxt))
        SEL_CTRL: begin
          ctrl_nxt  = ctrl_wr & shreg_pkg::CTRL_MASK;
          bresp_nxt = shreg_pkg::RESP_OKAY;
        end
        // status is read-only; writes there are accepted and dropped
        SEL_STAT: bresp_nxt = shreg_pkg::RESP_OKAY;
        SEL_NONE: bresp_nxt = shreg_pkg::RESP_SLVERR;
      endcase
      bvalid_nxt = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      bvalid_r  <= 1'b0;
      bresp_r   <= shreg_pkg::RESP_OKAY;
      waddr_r   <= '0;
      wdata_r   <= '0;
      wstrb_r   <= '0;
      ctrl_r    <= shreg_pkg::CTRL_RESET;
    end else begin
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      waddr_r   <= waddr_nxt;
      wdata_r   <= wdata_nxt;
      wstrb_r   <= wstrb_nxt;
      ctrl_r    <= ctrl_nxt;
    end
  end

  // ----------------------------------------------------------------
  // input source select: pins or control register
  // ----------------------------------------------------------------
  logic                         sw_src;
  logic                         sel_clear_n;
  logic                         sel_mhi;
  logic                         sel_mlo;
  logic                         sel_sr;
  logic                         sel_sl;
  logic [shreg_pkg::STAGES-1:0] sel_par;
  logic                         sel_clk;
  logic [shreg_pkg::STAGES-1:0] stage;
  logic                         clk_level;

  // switching source while the two clock levels differ yields one edge
  always_comb begin
    sw_src      = ctrl_r[shreg_pkg::CTRL_SRC_BIT];
    sel_clear_n = sw_src ? ctrl_r[shreg_pkg::CTRL_CLR_N_BIT] : clear_n_in;
    sel_mhi     = sw_src ? ctrl_r[shreg_pkg::CTRL_MHI_BIT]   : mode_sel_hi_in;
    sel_mlo     = sw_src ? ctrl_r[shreg_pkg::CTRL_MLO_BIT]   : mode_sel_lo_in;
    sel_sr      = sw_src ? ctrl_r[shreg_pkg::CTRL_SR_BIT]    : ser_right_in;
    sel_sl      = sw_src ? ctrl_r[shreg_pkg::CTRL_SL_BIT]    : ser_left_in;
    sel_par     = sw_src ? ctrl_r[shreg_pkg::CTRL_PAR_LSB +: shreg_pkg::STAGES] : par_data_in;
    sel_clk     = sw_src ? ctrl_r[shreg_pkg::CTRL_CLK_BIT]   : shift_clk_in;
  end

  shreg_core u_core (
    .ref_clk_in     (ref_clk_in),
    .srst_in        (srst_in),
    .clear_n_in     (sel_clear_n),
    .mode_sel_hi_in (sel_mhi),
    .mode_sel_lo_in (sel_mlo),
    .ser_right_in   (sel_sr),
    .ser_left_in    (sel_sl),
    .par_data_in    (sel_par),
    .shift_clk_in   (sel_clk),
    .stage_out      (stage),
    .clk_level_out  (clk_level)
  );

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  logic                          arready_r, arready_nxt;
  logic                          rvalid_r,  rvalid_nxt;
  logic [1:0]                    rresp_r,   rresp_nxt;
  logic [shreg_pkg::DATA_W-1:0]  rdata_r,   rdata_nxt;
  logic [shreg_pkg::DATA_W-1:0]  stat_word;

  always_comb begin
    stat_word = '0;
    stat_word[shreg_pkg::STAT_STAGE_LSB +: shreg_pkg::STAGES] = stage;
    stat_word[shreg_pkg::STAT_CLK_BIT] = clk_level;
    arready_nxt = arready_r;
    rvalid_nxt  = rvalid_r;
    rresp_nxt   = rresp_r;
    rdata_nxt   = rdata_r;
    if (rvalid_r) begin
      if (s_axi_rready_in) begin
        rvalid_nxt  = 1'b0;
        arready_nxt = 1'b1;
      end
    end else if (s_axi_arvalid_in && arready_r) begin
      arready_nxt = 1'b0;
      rvalid_nxt  = 1'b1;
      unique case (reg_sel(s_axi_araddr_in))
        SEL_CTRL: begin
          rdata_nxt = ctrl_r;
          rresp_nxt = shreg_pkg::RESP_OKAY;
        end
        SEL_STAT: begin
          rdata_nxt = stat_word;
          rresp_nxt = shreg_pkg::RESP_OKAY;
        end
        SEL_NONE: begin
          rdata_nxt = '0;
          rresp_nxt = shreg_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rresp_r   <= shreg_pkg::RESP_OKAY;
      rdata_r   <= '0;
    end else begin
      arready_r <= arready_nxt;
      rvalid_r  <= rvalid_nxt;
      rresp_r   <= rresp_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from flip-flops
  // ----------------------------------------------------------------
  assign stage_out         = stage;
  assign s_axi_awready_out = awready_r;
  assign s_axi_wready_out  = wready_r;
  assign s_axi_bvalid_out  = bvalid_r;
  assign s_axi_bresp_out   = bresp_r;
  assign s_axi_arready_out = arready_r;
  assign s_axi_rvalid_out  = rvalid_r;
  assign s_axi_rresp_out   = rresp_r;
  assign s_axi_rdata_out   = rdata_r;

endmodule

`default_nettype wire

//--- hw/shreg_pkg.sv
// constants shared by the shift register core and its bus wrapper
package shreg_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int unsigned STAGES     = 4;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned STRB_W     = DATA_W / 8;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] STAT_OFS = 8'h04;

  // control register fields
  localparam int unsigned CTRL_SRC_BIT   = 0;
  localparam int unsigned CTRL_CLR_N_BIT = 1;
  localparam int unsigned CTRL_MLO_BIT   = 2;
  localparam int unsigned CTRL_MHI_BIT   = 3;
  localparam int unsigned CTRL_SR_BIT    = 4;
  localparam int unsigned CTRL_SL_BIT    = 5;
  localparam int unsigned CTRL_PAR_LSB   = 8;
  localparam int unsigned CTRL_CLK_BIT   = 16;
  localparam logic [DATA_W-1:0] CTRL_MASK  = 32'h0001_0f3f;
  localparam logic [DATA_W-1:0] CTRL_RESET = 32'h0000_0002;

  // status register fields
  localparam int unsigned STAT_STAGE_LSB = 0;
  localparam int unsigned STAT_CLK_BIT   = 8;

  // ----------------------------------------------------------------
  // bus answers
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ----------------------------------------------------------------
  // operating modes, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    MODE_HOLD  = 4'b0001,
    MODE_RIGHT = 4'b0010,
    MODE_LEFT  = 4'b0100,
    MODE_LOAD  = 4'b1000
  } mode_type;

  localparam logic [STAGES-1:0] STAGE_RESET = 4'h0;

endpackage

//--- hw/shreg_core.sv
// four-stage universal shift register, stepped on rising edges of a sampled clock level
`timescale 1ns/1ps
`default_nettype none

module shreg_core (
  input  wire logic                          ref_clk_in,
  input  wire logic                          srst_in,
  input  wire logic                          clear_n_in,
  input  wire logic                          mode_sel_hi_in,
  input  wire logic                          mode_sel_lo_in,
  input  wire logic                          ser_right_in,
  input  wire logic                          ser_left_in,
  input  wire logic [shreg_pkg::STAGES-1:0]  par_data_in,
  input  wire logic                          shift_clk_in,
  output logic      [shreg_pkg::STAGES-1:0]  stage_out,
  output logic                               clk_level_out
);

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  function automatic shreg_pkg::mode_type mode_of(input logic hi, input logic lo);
    shreg_pkg::mode_type m;
    unique case ({hi, lo})
      2'b11:   m = shreg_pkg::MODE_LOAD;
      2'b01:   m = shreg_pkg::MODE_RIGHT;
      2'b10:   m = shreg_pkg::MODE_LEFT;
      default: m = shreg_pkg::MODE_HOLD;
    endcase
    return m;
  endfunction

  logic [shreg_pkg::STAGES-1:0] stage_r;
  logic [shreg_pkg::STAGES-1:0] stage_nxt;
  logic                         clk_prev_r;
  logic                         clk_prev_nxt;
  logic                         rise;
  shreg_pkg::mode_type          mode;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    clk_prev_nxt = shift_clk_in;
    // only a low-to-high step moves data; high level and falling edge do nothing
    rise         = shift_clk_in & ~clk_prev_r;
    mode         = mode_of(mode_sel_hi_in, mode_sel_lo_in);
    stage_nxt    = stage_r;
    if (!clear_n_in) begin
      stage_nxt = shreg_pkg::STAGE_RESET;
    end else if (rise) begin
      unique case (mode)
        shreg_pkg::MODE_LOAD:  stage_nxt = par_data_in;
        // stage 0 is A; parallel data not consulted while shifting
        shreg_pkg::MODE_RIGHT: stage_nxt = {stage_r[shreg_pkg::STAGES-2:0], ser_right_in};
        shreg_pkg::MODE_LEFT:  stage_nxt = {ser_left_in, stage_r[shreg_pkg::STAGES-1:1]};
        shreg_pkg::MODE_HOLD:  stage_nxt = stage_r;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      stage_r    <= shreg_pkg::STAGE_RESET;
      clk_prev_r <= 1'b0;
    end else begin
      stage_r    <= stage_nxt;
      clk_prev_r <= clk_prev_nxt;
    end
  end

  assign stage_out     = stage_r;
  assign clk_level_out = clk_prev_r;

endmodule

`default_nettype wire

//--- verification/shreg_asserts.sv
// pin-side assertions for the shift register top
`timescale 1ns/1ps
`default_nettype none
module shreg_asserts (
  input wire logic        ref_clk_in,
  input wire logic        srst_in,
  input wire logic        clear_n_in,
  input wire logic        mode_sel_hi_in,
  input wire logic        mode_sel_lo_in,
  input wire logic        ser_right_in,
  input wire logic        ser_left_in,
  input wire logic [3:0]  par_data_in,
  input wire logic        shift_clk_in,
  input wire logic [3:0]  stage_out,
  input wire logic [7:0]  s_axi_awaddr_in,
  input wire logic        s_axi_awvalid_in,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0]  s_axi_wstrb_in,
  input wire logic        s_axi_wvalid_in,
  input wire logic        s_axi_wready_out
);
  logic clk_q_r, clk_q_nxt, sw_r, sw_nxt, sw_d_r, pin_ok, step;
  // ----------------------------------------------------------------
  // pin clock sample, software-control mask
  // ----------------------------------------------------------------
  always_comb begin
    clk_q_nxt = shift_clk_in;
    sw_nxt = sw_r;
    if (s_axi_wvalid_in && s_axi_wready_out && s_axi_wstrb_in[0]) begin
      if (s_axi_wdata_in[0])
        sw_nxt = 1'b1;
      else if (s_axi_awvalid_in && s_axi_awaddr_in == shreg_pkg::CTRL_OFS)
        sw_nxt = 1'b0;
    end
  end
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      clk_q_r <= 1'b0;
      sw_r    <= 1'b0;
      sw_d_r  <= 1'b0;
    end else begin
      clk_q_r <= clk_q_nxt;
      sw_r    <= sw_nxt;
      sw_d_r  <= sw_r;
    end
  end
  // a source switch may cost one stray step, so one more cycle is masked
  assign pin_ok = !sw_r && !sw_d_r;
  assign step   = pin_ok && clear_n_in && shift_clk_in && !clk_q_r;
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);
  clear_low_a: assert property (pin_ok && !clear_n_in |=> stage_out == 4'h0)
    else $error("stages not cleared");
  hold_clk_low_a: assert property (pin_ok && clear_n_in && !shift_clk_in |=> $stable(stage_out))
    else $error("stages moved with clock low");
  hold_clk_high_a: assert property (
    pin_ok && clear_n_in && shift_clk_in && clk_q_r |=> $stable(stage_out))
    else $error("stages moved without rising edge");
  load_par_a: assert property (step && mode_sel_hi_in && mode_sel_lo_in |=> stage_out == $past(par_data_in))
    else $error("parallel load wrong");
  shift_right_a: assert property (
    step && !mode_sel_hi_in && mode_sel_lo_in |=> stage_out == {$past(stage_out[2:0]), $past(ser_right_in)})
    else $error("right shift wrong");
  shift_left_a: assert property (
    step && mode_sel_hi_in && !mode_sel_lo_in |=> stage_out == {$past(ser_left_in), $past(stage_out[3:1])})
    else $error("left shift wrong");
  mode_hold_a: assert property (step && !mode_sel_hi_in && !mode_sel_lo_in |=> $stable(stage_out))
    else $error("hold mode moved stages");
  wready_drop_a: assert property (s_axi_wvalid_in && s_axi_wready_out |=> !s_axi_wready_out)
    else $error("wready stayed after handshake");
endmodule
`default_nettype wire

//--- verification/pin_driver.sv
// far-side model: sets mode and data, then pulses the shift clock
`timescale 1ns/1ps
`default_nettype none
module pin_driver (
  input  wire logic       ref_clk_in,
  input  wire logic       srst_in,
  input  wire logic       start_in,
  input  wire logic [8:0] cmd_in,
  input  wire logic [3:0] high_len_in,
  output logic      [8:0] pins_out,
  output logic            shift_clk_out,
  output logic            done_out
);
  logic [1:0] ph_r, ph_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [8:0] pins_nxt;
  logic       clk_nxt, done_nxt;
  always_comb begin
    ph_nxt   = ph_r;
    cnt_nxt  = cnt_r;
    pins_nxt = pins_out;
    clk_nxt  = shift_clk_out;
    done_nxt = 1'b0;
    case (ph_r)
      2'h0: if (start_in) begin
        pins_nxt = cmd_in; // levels settle a cycle before the edge
        ph_nxt   = 2'h1;
      end
      2'h1: begin
        clk_nxt = 1'b1;
        cnt_nxt = high_len_in;
        ph_nxt  = 2'h2;
      end
      default: if (cnt_r <= 4'h1) begin
        clk_nxt  = 1'b0; // low again before the next request
        done_nxt = 1'b1;
        ph_nxt   = 2'h0;
      end else begin
        cnt_nxt = cnt_r - 4'h1;
      end
    endcase
  end
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      ph_r          <= 2'h0;
      cnt_r         <= 4'h0;
      pins_out      <= 9'h100;
      shift_clk_out <= 1'b0;
      done_out      <= 1'b0;
    end else begin
      ph_r          <= ph_nxt;
      cnt_r         <= cnt_nxt;
      pins_out      <= pins_nxt;
      shift_clk_out <= clk_nxt;
      done_out      <= done_nxt;
    end
  end
endmodule
`default_nettype wire

//--- verification/tb_universal_shift_register_4bit.sv
// bench: pin table, long clock, reset, register access
`timescale 1ns/1ps
`default_nettype none
module tb_universal_shift_register_4bit;
  logic        clk = 1'b0, srst = 1'b1, start = 1'b0;
  logic [8:0]  cmd = 9'h100, pins;
  logic [3:0]  hl = 4'h1, stg, ws = 4'h0;
  logic        sclk, done, awr, wr, bv, arr, rv;
  logic [7:0]  awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rd;
  logic        awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic [1:0]  bresp, rresp;
  int          error_cnt = 0;
  int          total_checks = 0;
  // {clear_n, hi, lo, ser_right, ser_left, par, expected stages}
  logic [12:0] rows [10] = '{13'h1faa, 13'h1605, 13'h14fa, 13'h190d, 13'h18f6,
                             13'h1396, 13'h0350, 13'h1cff, 13'h0cf0, 13'h1cff};
  always #50 clk = ~clk;
  pin_driver drv (.ref_clk_in(clk), .srst_in(srst), .start_in(start), .cmd_in(cmd),
    .high_len_in(hl), .pins_out(pins), .shift_clk_out(sclk), .done_out(done));
  shreg_top DUT (.ref_clk_in(clk), .srst_in(srst), .clear_n_in(pins[8]), .mode_sel_hi_in(pins[7]),
    .mode_sel_lo_in(pins[6]), .ser_right_in(pins[5]), .ser_left_in(pins[4]), .par_data_in(pins[3:0]),
    .shift_clk_in(sclk), .stage_out(stg), .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv),
    .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws), .s_axi_wvalid_in(wv),
    .s_axi_wready_out(wr), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv), .s_axi_bready_in(br),
    .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_rdata_out(rd),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv), .s_axi_rready_in(rr));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic step(input logic [8:0] c, input logic [3:0] h);
    @(posedge clk);
    cmd   <= c;
    hl    <= h;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    do @(posedge clk); while (done !== 1'b1);
  endtask
  task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] e);
    @(posedge clk);
    awa <= a;
    wd  <= d;
    ws  <= s;
    awv <= 1'b1;
    wv  <= 1'b1;
    br  <= 1'b1;
    fork
      begin
        do @(posedge clk); while (awr !== 1'b1);
        awv <= 1'b0;
      end
      begin
        do @(posedge clk); while (wr !== 1'b1);
        wv <= 1'b0;
      end
    join
    do @(posedge clk); while (bv !== 1'b1);
    chk("bresp", {30'h0, bresp}, {30'h0, e});
    br <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rr  <= 1'b1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge clk); while (rv !== 1'b1);
    chk("rdata", rd, e);
    chk("rresp", {30'h0, rresp}, {30'h0, er});
    rr <= 1'b0;
  endtask
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    foreach (rows[i]) begin
      step(rows[i][12:4], 4'h1);
      chk("stage", {28'h0, stg}, {28'h0, rows[i][3:0]});
    end
    // table rows miss sequences, so awkward cases follow
    step(9'h140, 4'h6);
    chk("long high", {28'h0, stg}, 32'h0000_000e);
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    chk("reset stage", {28'h0, stg}, 32'h0);
    rdc(shreg_pkg::CTRL_OFS, shreg_pkg::CTRL_RESET, shreg_pkg::RESP_OKAY);
    rdc(8'h08, 32'h0, shreg_pkg::RESP_SLVERR);
    wrc(8'h0c, 32'h0, 4'hf, shreg_pkg::RESP_SLVERR);
    wrc(shreg_pkg::CTRL_OFS, 32'hfffe_f0c2, 4'hf, shreg_pkg::RESP_OKAY);
    wrc(shreg_pkg::CTRL_OFS, 32'hffff_ffff, 4'h2, shreg_pkg::RESP_OKAY);
    rdc(shreg_pkg::CTRL_OFS, 32'h0000_0f02, shreg_pkg::RESP_OKAY);
    // register-driven steps: a held-high clock and a falling edge must not shift
    wrc(shreg_pkg::CTRL_OFS, 32'h0000_050f, 4'hf, shreg_pkg::RESP_OKAY);
    wrc(shreg_pkg::CTRL_OFS, 32'h0001_050f, 4'hf, shreg_pkg::RESP_OKAY);
    rdc(shreg_pkg::STAT_OFS, 32'h0000_0105, shreg_pkg::RESP_OKAY);
    wrc(shreg_pkg::CTRL_OFS, 32'h0001_0517, 4'hf, shreg_pkg::RESP_OKAY);
    rdc(shreg_pkg::STAT_OFS, 32'h0000_0105, shreg_pkg::RESP_OKAY);
    wrc(shreg_pkg::CTRL_OFS, 32'h0000_0517, 4'hf, shreg_pkg::RESP_OKAY);
    rdc(shreg_pkg::STAT_OFS, 32'h0000_0005, shreg_pkg::RESP_OKAY);
    wrc(shreg_pkg::CTRL_OFS, 32'h0001_0517, 4'hf, shreg_pkg::RESP_OKAY);
    rdc(shreg_pkg::STAT_OFS, 32'h0000_010b, shreg_pkg::RESP_OKAY);
    chk("sw stage", {28'h0, stg}, 32'h0000_000b);
    wrc(shreg_pkg::CTRL_OFS, 32'h0001_0515, 4'hf, shreg_pkg::RESP_OKAY);
    wrc(shreg_pkg::STAT_OFS, 32'h0000_00ff, 4'hf, shreg_pkg::RESP_OKAY);
    rdc(shreg_pkg::STAT_OFS, 32'h0000_0100, shreg_pkg::RESP_OKAY);
    wrc(shreg_pkg::CTRL_OFS, shreg_pkg::CTRL_RESET, 4'hf, shreg_pkg::RESP_OKAY);
    final_report();
  end
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    final_report();
  end
endmodule
bind shreg_top shreg_asserts chk_i (.ref_clk_in(ref_clk_in), .srst_in(srst_in), .clear_n_in(clear_n_in),
  .mode_sel_hi_in(mode_sel_hi_in), .mode_sel_lo_in(mode_sel_lo_in), .ser_right_in(ser_right_in),
  .ser_left_in(ser_left_in), .par_data_in(par_data_in), .shift_clk_in(shift_clk_in), .stage_out(stage_out),
  .s_axi_awaddr_in(s_axi_awaddr_in), .s_axi_awvalid_in(s_axi_awvalid_in), .s_axi_wdata_in(s_axi_wdata_in),
  .s_axi_wstrb_in(s_axi_wstrb_in), .s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_wready_out(s_axi_wready_out));
`default_nettype wire
